// ===== src/twi_pkg.sv
package twi_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] BUF_OFS = 4'h0;
  localparam logic [3:0] RELOAD_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  localparam logic [3:0] CTL1_OFS = 4'hc;
  localparam logic [3:0] CTL2_OFS = 4'h0;
  localparam logic [4:0] CTL2_OFS5 = 5'h10;

  // Status register fields
  localparam int STAT_BF_BIT = 0;
  localparam int STAT_START_BIT = 3;
  localparam int STAT_STOP_BIT = 4;
  localparam logic [7:0] STAT_RW_MASK = 8'hc0;

  // Control one fields
  localparam int CTL1_WRITE_COLLISION_FLAG_BIT = 7;
  localparam int CTL1_OV_BIT = 6;

  // Control two fields
  localparam int CTL2_ACK_STATUS_BIT_BIT = 6;
  localparam int CTL2_ACK_DATA_BIT_BIT = 5;
  localparam int CTL2_ACK_SEQUENCE_ENABLE_BIT = 4;
  localparam int CTL2_RECEIVE_ENABLE_BIT_BIT = 3;

  // Reset value and minimum reload
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] RELOAD_MIN = 7'h01;

  // Bits per byte and the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TX_LOW,
    ST_TX_HIGH,
    ST_RX_LOW,
    ST_RX_HIGH,
    ST_ACK_LOW,
    ST_ACK_HIGH
  } engine_type;

  // Two-wire pin bundle as seen by the block
  typedef struct packed {
    logic sclOut;
    logic sclOe_n;
    logic sdaOut;
    logic sdaOe_n;
  } pin_drive_type;

endpackage

// ===== src/i2c_master_byte_engine.sv
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Behaviour
// R1 - Received byte moves to buffer, flag set
// R2 - Buffer write loads buffer and shifter
// R3 - Low seven reload bits set bit period
// R4 - Status low six read-only, top two writable
// R5 - Transmit write sets full, starts generator
// R6 - Data changes after clock low; equal phases
// R7 - Address: seven bits then direction bit
// R8 - After eighth fall clear full, release data
// R9 - Sample acknowledge at ninth fall
// R10 - After ninth: flag, clock low, idle
// R11 - Write during transmit: collision, discarded
// R12 - Target pulls data low to acknowledge
// R13 - Receive enable ignored during acknowledge
// R14 - Receive toggles clock, shifts data in
// R15 - Eighth receive fall: store, flag, stop
// R16 - Receive full flag cleared by read; here only a read while idle clears it
// R17 - Acknowledge enable sends acknowledge bit
// R18 - Overflow when byte arrives while full
// R19 - Write during receive: collision, ignored
// R20 - Flags on start and stop conditions
// R21 - Ten-bit address as two buffer writes
// R22 - Lines only pulled low or released
module i2c_master_byte_engine
  import twi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sclIn,
  input wire logic sdaIn,
  output twi_pkg::pin_drive_type pins,
  output logic portIrqFlag
);

  // Whole block state
  typedef struct packed {
    engine_type st;
    logic [7:0] rxTxBuf;
    logic [7:0] shiftReg;
    logic [6:0] reload;
    logic [6:0] brgCnt;
    logic [3:0] bitCnt;
    logic [1:0] statHigh;
    logic bufFull;
    logic write_collision_flag;
    logic rxOv;
    logic ack_status_bit;
    logic ack_data_bit;
    logic ack_sequence_enable;
    logic rxEn;
    logic startSeen;
    logic stopSeen;
    logic irq;
    logic sclDrvLow;
    logic sdaDrvLow;
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic sclPrev;
    logic sdaPrev;
    logic ackDone;
    logic busy;
    logic [31:0] rdata;
    logic ack;
    logic waitReq; // Registered bus wait, high unless answering
  } state_type;

  state_type s_q;
  state_type s_d;

  // Reload value, at least one cycle per phase
  function automatic logic [6:0] reloadOf(input logic [6:0] r);
    reloadOf = (r == 7'h00) ? RELOAD_MIN : r;
  endfunction

  // Register offset match on the byte address
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a == o);
  endfunction

  // Next-state logic
  always_comb
  begin
    logic rollover;
    logic sclNow;
    logic sdaNow;
    logic bufWr;
    logic bufRd;
    rollover = 1'b0;
    s_d = s_q;
    s_d.sclSync = {s_q.sclSync[0], sclIn};
    s_d.sdaSync = {s_q.sdaSync[0], sdaIn};
    sclNow = s_q.sclSync[1];
    sdaNow = s_q.sdaSync[1];
    s_d.sclPrev = sclNow;
    s_d.sdaPrev = sdaNow;
    s_d.ack = 1'b0;
    s_d.rdata = 32'h0000_0000;
    bufWr = 1'b0;
    bufRd = 1'b0;

    // Bit-period generator counts while running
    if (s_q.st != ST_IDLE)
    begin
      if (s_q.brgCnt == 7'h00)
      begin
        rollover = 1'b1;
        // R3 reload from seven bits
        s_d.brgCnt = reloadOf(s_q.reload) - 7'h01;
      end
      else
      begin
        s_d.brgCnt = s_q.brgCnt - 7'h01;
      end
    end

    // Bus slave: answer one cycle after the request
    if ((read || write) && !s_q.ack)
    begin
      s_d.ack = 1'b1;
      if (write)
      begin
        if (hit(address, {1'b0, BUF_OFS}))
        begin
          bufWr = 1'b1;
        end
        else if (hit(address, {1'b0, RELOAD_OFS}))
        begin
          s_d.reload = writedata[6:0];
        end
        else if (hit(address, {1'b0, STAT_OFS}))
        begin
          // R4 only top two bits writable
          s_d.statHigh = writedata[7:6];
        end
        else if (hit(address, {1'b0, CTL1_OFS}))
        begin
          s_d.write_collision_flag = writedata[CTL1_WRITE_COLLISION_FLAG_BIT];
          s_d.rxOv = writedata[CTL1_OV_BIT];
          s_d.startSeen = s_d.startSeen & writedata[STAT_START_BIT];
          s_d.stopSeen = s_d.stopSeen & writedata[STAT_STOP_BIT];
          s_d.irq = s_d.irq & writedata[0];
        end
        else if (hit(address, CTL2_OFS5))
        begin
          s_d.ack_data_bit = writedata[CTL2_ACK_DATA_BIT_BIT];
          // R13 receive enable only when idle after acknowledge
          if (writedata[CTL2_RECEIVE_ENABLE_BIT_BIT] && s_q.st == ST_IDLE && s_q.ackDone)
          begin
            s_d.rxEn = 1'b1;
            s_d.st = ST_RX_LOW;
            s_d.bitCnt = 4'h0;
            s_d.brgCnt = reloadOf(s_q.reload) - 7'h01;
          end
          // R17 acknowledge sequence request
          if (writedata[CTL2_ACK_SEQUENCE_ENABLE_BIT] && s_q.st == ST_IDLE)
          begin
            s_d.ack_sequence_enable = 1'b1;
            s_d.st = ST_ACK_LOW;
            s_d.sdaDrvLow = !writedata[CTL2_ACK_DATA_BIT_BIT];
            s_d.brgCnt = reloadOf(s_q.reload) - 7'h01;
          end
        end
      end
      else
      begin
        if (hit(address, {1'b0, BUF_OFS}))
        begin
          s_d.rdata = {24'h000000, s_q.rxTxBuf};
          bufRd = 1'b1;
        end
        else if (hit(address, {1'b0, RELOAD_OFS}))
        begin
          s_d.rdata = {25'h0, s_q.reload};
        end
        else if (hit(address, {1'b0, STAT_OFS}))
        begin
          s_d.rdata = {24'h000000, s_q.statHigh, 1'b0, s_q.stopSeen,
                       s_q.startSeen, 2'b00, s_q.bufFull};
        end
        else if (hit(address, {1'b0, CTL1_OFS}))
        begin
          s_d.rdata = {24'h000000, s_q.write_collision_flag, s_q.rxOv, 5'h00, s_q.irq};
        end
        else if (hit(address, CTL2_OFS5))
        begin
          s_d.rdata = {24'h000000, 1'b0, s_q.ack_status_bit, s_q.ack_data_bit,
                       s_q.ack_sequence_enable, s_q.rxEn, 3'b000};
        end
      end
    end

    // Bus wait drops only in the answer cycle
    s_d.waitReq = !s_d.ack;

    // R20 start and stop, after the clears so a set wins
    if (sclNow && s_q.sclPrev && s_q.sdaPrev && !sdaNow)
    begin
      s_d.startSeen = 1'b1;
      s_d.irq = 1'b1;
    end
    if (sclNow && s_q.sclPrev && !s_q.sdaPrev && sdaNow)
    begin
      s_d.stopSeen = 1'b1;
      s_d.irq = 1'b1;
    end

    // R16 read of the buffer clears full only when idle
    if (bufRd && s_q.st == ST_IDLE)
    begin
      s_d.bufFull = 1'b0;
    end

    // Buffer write handling
    if (bufWr)
    begin
      if (s_q.st != ST_IDLE)
      begin
        // R11 R19 collision, write dropped
        s_d.write_collision_flag = 1'b1;
      end
      else
      begin
        // R2 R5 R21 load buffer and shifter, start
        s_d.rxTxBuf = writedata[7:0];
        s_d.shiftReg = writedata[7:0];
        s_d.bufFull = 1'b1;
        s_d.st = ST_TX_LOW;
        s_d.bitCnt = 4'h0;
        s_d.brgCnt = reloadOf(s_q.reload) - 7'h01;
        s_d.ackDone = 1'b0;
        // R6 R7 first bit placed while clock low
        s_d.sclDrvLow = 1'b1;
        s_d.sdaDrvLow = !writedata[7];
      end
    end

    // Engine sequencing on generator rollover
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.busy = 1'b0;
      end
      ST_TX_LOW:
      begin
        if (rollover)
        begin
          // R6 release clock for one period
          s_d.sclDrvLow = 1'b0;
          s_d.st = ST_TX_HIGH;
        end
      end
      ST_TX_HIGH:
      begin
        if (rollover)
        begin
          s_d.sclDrvLow = 1'b1;
          s_d.bitCnt = s_q.bitCnt + 4'h1;
          if (s_q.bitCnt == BYTE_BITS)
          begin
            // R9 R12 ninth fall samples acknowledge
            s_d.ack_status_bit = sdaNow;
            // R10 flag, hold clock low, data released
            s_d.irq = 1'b1;
            s_d.sdaDrvLow = 1'b0;
            s_d.ackDone = 1'b1;
            s_d.st = ST_IDLE;
          end
          else if (s_q.bitCnt == BYTE_BITS - 4'h1)
          begin
            // R8 eighth fall clears full, releases data
            s_d.bufFull = 1'b0;
            s_d.sdaDrvLow = 1'b0;
            s_d.st = ST_TX_LOW;
          end
          else
          begin
            // R6 R7 next bit after clock falls
            s_d.shiftReg = {s_q.shiftReg[6:0], 1'b0};
            s_d.sdaDrvLow = !s_q.shiftReg[6];
            s_d.st = ST_TX_LOW;
          end
        end
      end
      ST_RX_LOW:
      begin
        s_d.sdaDrvLow = 1'b0;
        if (rollover)
        begin
          // R14 toggle clock high
          s_d.sclDrvLow = 1'b0;
          s_d.st = ST_RX_HIGH;
        end
      end
      ST_RX_HIGH:
      begin
        if (rollover)
        begin
          // R14 shift line level in, clock low
          s_d.sclDrvLow = 1'b1;
          s_d.shiftReg = {s_q.shiftReg[6:0], sdaNow};
          s_d.bitCnt = s_q.bitCnt + 4'h1;
          if (s_q.bitCnt == BYTE_BITS - 4'h1)
          begin
            // R15 R1 store byte, flag, stop generator
            s_d.rxEn = 1'b0;
            s_d.rxTxBuf = {s_q.shiftReg[6:0], sdaNow};
            s_d.irq = 1'b1;
            s_d.bufFull = 1'b1;
            s_d.ackDone = 1'b0;
            // R18 overflow while previous still full
            if (s_q.bufFull)
            begin
              s_d.rxOv = 1'b1;
            end
            s_d.st = ST_IDLE;
          end
          else
          begin
            s_d.st = ST_RX_LOW;
          end
        end
      end
      ST_ACK_LOW:
      begin
        if (rollover)
        begin
          s_d.sclDrvLow = 1'b0;
          s_d.st = ST_ACK_HIGH;
        end
      end
      ST_ACK_HIGH:
      begin
        if (rollover)
        begin
          // R17 acknowledge bit done, release data
          s_d.sclDrvLow = 1'b1;
          s_d.sdaDrvLow = 1'b0;
          s_d.ack_sequence_enable = 1'b0;
          s_d.ackDone = 1'b1;
          s_d.irq = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
    s_d.busy = (s_d.st != ST_IDLE);
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.sclSync <= 2'b11;
      s_q.sdaSync <= 2'b11;
      s_q.sclPrev <= 1'b1;
      s_q.sdaPrev <= 1'b1;
      s_q.ackDone <= 1'b1;
      s_q.waitReq <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign readdata = s_q.rdata;
  assign waitrequest = s_q.waitReq;
  // R22 open-drain: drive low or release
  assign pins.sclOut = 1'b0;
  assign pins.sclOe_n = !s_q.sclDrvLow;
  assign pins.sdaOut = 1'b0;
  assign pins.sdaOe_n = !s_q.sdaDrvLow;
  assign portIrqFlag = s_q.irq;

endmodule

// ===== verif/twi_chk_sva.sv
`timescale 1ns/1ps
module twi_chk
  import twi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire twi_pkg::pin_drive_type pins,
  input wire logic portIrqFlag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  openDrain_a: assert property (!pins.sclOut && !pins.sdaOut)
    else $error("line driven high");
  sdaSteady_a: assert property ($changed(pins.sdaOe_n) |-> !pins.sclOe_n)
    else $error("data moved with clock high");
  irqSclLow_a: assert property ($rose(portIrqFlag) && $changed(pins.sclOe_n) |-> !pins.sclOe_n)
    else $error("flag without clock low");
  irqSdaFree_a: assert property ($rose(portIrqFlag) |-> pins.sdaOe_n)
    else $error("flag with data held");
  irqSticky_a: assert property (portIrqFlag && !write |=> portIrqFlag)
    else $error("flag dropped alone");
  sclParked_a: assert property
    ($rose(portIrqFlag) && $fell(pins.sclOe_n) ##1 (!write)[*4] |-> !pins.sclOe_n)
    else $error("clock left low hold");
  waitFirst_a: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait cycle");
  waitOnce_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait too long");
endmodule

bind i2c_master_byte_engine twi_chk chk_u (
  .ref_clk(ref_clk),
  .srst(srst),
  .read(read),
  .write(write),
  .waitrequest(waitrequest),
  .pins(pins),
  .portIrqFlag(portIrqFlag)
);

// ===== verif/twi_target.sv
`timescale 1ns/1ps
module twi_target (
  input wire logic scl,
  input wire logic rxMode,
  input wire logic ackOn,
  input wire logic [7:0] sendByte,
  output logic pullLow
);
  logic [3:0] riseN = 4'h0; // Clock rises in frame
  logic [3:0] idx = 4'h0; // Slot after last fall
  logic sclLast = 1'b1; // Last known clock level
  // Count rises, move slot on each fall; unknown levels make no edge
  always @(scl)
  begin
    if (scl === 1'b1 && sclLast === 1'b0)
      riseN <= riseN + 4'h1;
    else if (scl === 1'b0 && sclLast === 1'b1)
    begin
      if (riseN == 4'h9)
      begin
        riseN <= 4'h0;
        idx <= 4'h0;
      end
      else
        idx <= riseN;
    end
    sclLast <= scl;
  end
  assign pullLow = rxMode ? (idx < 4'h8 && !sendByte[3'h7 - idx[2:0]]) : (idx == 4'h8 && ackOn);
endmodule

// ===== verif/i2c_master_byte_engine_tb.sv
`timescale 1ns/1ps
module i2c_master_byte_engine_tb;
  import twi_pkg::*;
  localparam logic [4:0] aBuf = {1'b0, BUF_OFS};
  localparam logic [4:0] aRld = {1'b0, RELOAD_OFS};
  localparam logic [4:0] aStat = {1'b0, STAT_OFS};
  localparam logic [4:0] aCtl1 = {1'b0, CTL1_OFS};
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] address = 5'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  pin_drive_type pins;
  logic portIrqFlag;
  logic rxMode = 1'b0;
  logic ackOn = 1'b1;
  logic [7:0] sendByte = 8'h00;
  logic pullLow;
  logic extPull = 1'b0; // Another controller pulling data
  logic [8:0] capt = 9'h0; // Bits seen at clock rises
  logic [7:0] rd;
  logic [7:0] hiCnt = 8'h0;
  logic [7:0] hiLen = 8'h0; // Last clock-high length
  int failures = 0;
  int nChecks = 0;
  wire scl = pins.sclOe_n;
  wire sda = pins.sdaOe_n & !pullLow & !extPull;
  always #4 ref_clk = ~ref_clk;
  i2c_master_byte_engine dut_u (.ref_clk(ref_clk), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sclIn(scl), .sdaIn(sda), .pins(pins),
    .portIrqFlag(portIrqFlag));
  twi_target tgt_u (.scl(scl), .rxMode(rxMode), .ackOn(ackOn), .sendByte(sendByte),
    .pullLow(pullLow));
  // Wire sampler
  always @(posedge scl) capt <= {capt[7:0], sda};
  // Clock-high length meter
  always @(posedge ref_clk)
  begin
    if (scl)
      hiCnt <= hiCnt + 8'h1;
    else if (hiCnt != 8'h0)
    begin
      hiLen <= hiCnt;
      hiCnt <= 8'h0;
    end
  end
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Avalon cycle held until wait drops
  task automatic bus(input logic [4:0] a, input logic wr, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      failures++;
      report_and_stop();
    end
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    cmp(rd & m, e);
  endtask
  // Wait for flag (0), data pulled (2) or freed (3)
  task automatic waitOn(input int k);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (n < 3000 && ((k == 0) ? portIrqFlag !== 1'b1 : pins.sdaOe_n !== k[0]));
    if (n >= 3000)
    begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic rxStart(input logic [7:0] b);
    sendByte <= b;
    bus(aCtl1, 1'b1, 8'h00);
    bus(CTL2_OFS5, 1'b1, 8'h08);
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    cmp({5'h0, pins.sclOe_n, pins.sdaOe_n, portIrqFlag}, 8'h06);
    chk(aStat, 8'hff, RESET_BYTE);
    chk(5'h14, 8'hff, 8'h00);
    bus(aStat, 1'b1, 8'hff);
    chk(aStat, 8'hff, STAT_RW_MASK);
    bus(aStat, 1'b1, 8'h00);
    // Another controller's start then stop on the idle bus
    extPull <= 1'b1;
    repeat (4) @(posedge ref_clk);
    extPull <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(aStat, 8'h18, 8'h18);
    chk(aCtl1, 8'h01, 8'h01);
    bus(aCtl1, 1'b1, 8'h00);
    chk(aStat, 8'h18, 8'h00);
    bus(aRld, 1'b1, 8'hff);
    chk(aRld, 8'hff, 8'h7f);
    // Five-cycle phases give the 80 ns link bit
    bus(aRld, 1'b1, 8'h05);
    bus(aBuf, 1'b1, 8'ha5);
    chk(aStat, 8'h01, 8'h01);
    bus(aBuf, 1'b1, 8'h3c);
    chk(aBuf, 8'hff, 8'ha5);
    waitOn(0);
    cmp(capt[8:1], 8'ha5);
    cmp(hiLen, 8'h05);
    chk(CTL2_OFS5, 8'h40, 8'h00);
    chk(aStat, 8'h01, 8'h00);
    chk(aCtl1, 8'h81, 8'h81);
    // Refused address byte
    ackOn <= 1'b0;
    bus(aCtl1, 1'b1, 8'h00);
    bus(aBuf, 1'b1, 8'h3c);
    waitOn(0);
    cmp(capt[8:1], 8'h3c);
    cmp({7'h00, capt[0]}, 8'h01);
    chk(CTL2_OFS5, 8'h40, 8'h40);
    rxMode <= 1'b1;
    rxStart(8'h96);
    bus(aBuf, 1'b1, 8'h11);
    waitOn(0);
    chk(CTL2_OFS5, 8'h48, 8'h40);
    chk(aCtl1, 8'h81, 8'h81);
    chk(aStat, 8'h01, 8'h01);
    chk(aBuf, 8'hff, 8'h96);
    chk(aStat, 8'h01, 8'h00);
    // Ack with receive enable given too early
    bus(CTL2_OFS5, 1'b1, 8'h18);
    waitOn(2);
    waitOn(3);
    cmp(capt[8:1], 8'h96);
    cmp({7'h00, capt[0]}, 8'h00);
    chk(CTL2_OFS5, 8'h08, 8'h00);
    // Second byte left unread, third overflows
    rxStart(8'h5a);
    waitOn(0);
    bus(CTL2_OFS5, 1'b1, 8'h10);
    waitOn(2);
    waitOn(3);
    rxStart(8'h5a);
    waitOn(0);
    chk(aCtl1, 8'h40, 8'h40);
    report_and_stop();
  end
endmodule
